// file: block_range_compare_map.vh
`ifndef BLOCK_RANGE_COMPARE_MAP_VH
`define BLOCK_RANGE_COMPARE_MAP_VH

// Word and data area geometry.
`define WORD_W        16
`define ADDR_W        5
`define DATA_WORDS    32
`define DATA_LAST     5'h1f
`define BASE_MAX      14'h000d
`define DIGIT_MAX     4'h9
`define RANGE_MAX     4'h9
`define WORD_RESET    16'h0000

// Bit positions inside the dedicated flag word.
`define FLAG_GREATER  15
`define FLAG_EQUAL    14
`define FLAG_LESS     13
`define FLAG_ERROR    11

// Controller state codes, one-hot.
`define ST_IDLE       2'b01
`define ST_RUN        2'b10

`endif

// file: range_eval.v
`timescale 1ns/100ps
`include "block_range_compare_map.vh"

// Tests one compare value against one lower/upper limit pair.
module range_eval
(
   input  wire [15:0] value_in,
   input  wire [15:0] lower_in,
   input  wire [15:0] upper_in,
   output reg         hit_out
);

   // Valid BCD orders the same way as plain binary, so the limits are
   // compared without converting them.
   always @*
   begin
      if (lower_in <= upper_in)
      begin
         // Equal limits fall here and match only their own value.
         hit_out = (value_in >= lower_in) && (value_in <= upper_in);
      end
      else
      begin
         // Reversed limits select everything outside the span.
         hit_out = (value_in >= lower_in) || (value_in <= upper_in);
      end
   end

endmodule

// file: block_range_compare.v
// Operation
// - Word compare sets greater, equal or less flag from first versus second.
// - Flag-derived values change only on scans where a compare executes.
// - Execution condition off: no comparison, result flags keep their state.
// - Low BCD digit of the base word gives N; evaluate N+1 ranges.
// - Range k uses lower limit at base+2k+1, upper at base+2k+2.
// - Lower below upper: result bit set when value lies inclusively inside.
// - Lower above upper: result bit set when value lies outside the span.
// - Base or limit words changed mid-run: remaining ranges use new contents.
// - Raise error flag when indirect word is not BCD or past the area.
// - Block compare reruns every scan its condition is on, rewriting result unless it ends in error.
// - Error is reported on the error bit of the dedicated flag word.
`timescale 1ns/100ps
`include "block_range_compare_map.vh"

module block_range_compare
(
   input  wire        clk_in,
   input  wire        rstn_in,
   input  wire        exec_cond_in,
   input  wire        word_compare_op_in,
   input  wire [15:0] first_word_in,
   input  wire [15:0] second_word_in,
   input  wire        block_range_compare_op_in,
   input  wire [15:0] compare_value_in,
   input  wire [4:0]  block_base_word_in,
   input  wire        base_indirect_in,
   input  wire        wr_en_in,
   input  wire [4:0]  wr_addr_in,
   input  wire [15:0] wr_data_in,
   input  wire [4:0]  rd_addr_in,
   output reg  [15:0] rd_data_out,
   output reg         greater_flag_out,
   output reg         equal_flag_out,
   output reg         less_flag_out,
   output reg         error_flag_out,
   output reg  [15:0] flag_word_out,
   output reg  [15:0] result_out,
   output reg         result_valid_out,
   output reg         busy_out
);

   // Checks that all four nibbles of a word are decimal digits.
   function bcd_ok;
      input [15:0] w;
      begin
         bcd_ok = (w[15:12] <= `DIGIT_MAX) && (w[11:8] <= `DIGIT_MAX) &&
                  (w[7:4] <= `DIGIT_MAX) && (w[3:0] <= `DIGIT_MAX);
      end
   endfunction

   // Converts a four-digit BCD word to its binary value.
   function [13:0] bcd_value;
      input [15:0] w;
      begin
         bcd_value = {10'h000, w[15:12]} * 14'h03e8 +
                     {10'h000, w[11:8]} * 14'h0064 +
                     {10'h000, w[7:4]} * 14'h000a +
                     {10'h000, w[3:0]};
      end
   endfunction

   wire [15:0] data_word [0:`DATA_WORDS-1];
   reg  [1:0]  state;
   reg  [13:0] base_index;
   reg  [3:0]  range_index;
   reg  [15:0] value_held;
   reg  [15:0] result_acc;

   reg  [1:0]  next_state;
   reg  [13:0] next_base_index;
   reg  [3:0]  next_range_index;
   reg  [15:0] next_value_held;
   reg  [15:0] next_result_acc;
   reg  [15:0] next_result;
   reg         next_result_valid;
   reg         next_greater;
   reg         next_equal;
   reg         next_less;
   reg         next_error;

   wire        idle_now;
   wire        word_go;
   wire        block_go;
   wire [15:0] pointer_word;
   wire        pointer_ok;
   wire [13:0] start_index;
   wire        base_in_area;
   wire [15:0] base_word;
   wire [3:0]  range_count;
   wire [14:0] lower_index;
   wire [14:0] upper_index;
   wire        limits_in_area;
   wire [15:0] lower_word;
   wire [15:0] upper_word;
   wire        range_hit;
   wire [15:0] hit_mask;

   // Data word area: one register per word, written by the sequencer.
   genvar g;
   generate
      for (g = 0; g < `DATA_WORDS; g = g + 1)
      begin : gen_word
         reg [15:0] word;
         always @(posedge clk_in or negedge rstn_in)
         begin
            if (!rstn_in)
            begin
               word <= `WORD_RESET;
            end
            else if (wr_en_in && (wr_addr_in == g))
            begin
               word <= wr_data_in;
            end
         end
         assign data_word[g] = word;
      end
   endgenerate

   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rd_data_out <= `WORD_RESET;
      end
      else
      begin
         rd_data_out <= data_word[rd_addr_in];
      end
   end

   // Requests are taken only while idle and only with the condition on;
   // with the condition off nothing is evaluated and nothing is written.
   assign idle_now = (state == `ST_IDLE);
   assign word_go  = idle_now && word_compare_op_in && exec_cond_in;
   assign block_go = idle_now && !word_compare_op_in &&
                     block_range_compare_op_in && exec_cond_in;

   // Indirect base: the named word holds the base index in BCD.
   assign pointer_word = data_word[block_base_word_in];
   assign pointer_ok   = !base_indirect_in || bcd_ok(pointer_word);
   assign start_index  = base_indirect_in ? bcd_value(pointer_word) :
                                            {9'h000, block_base_word_in};

   // The base word and the limits are read live each cycle, so a write
   // landing during the run is seen by every later range.
   assign base_in_area = (base_index <= `BASE_MAX);
   assign base_word    = data_word[base_index[4:0]];
   assign range_count  = base_word[3:0];
   assign lower_index  = {1'b0, base_index} +
                         {10'h000, range_index, 1'b1};
   assign upper_index  = lower_index + 15'h0001;
   assign limits_in_area = (upper_index <= {10'h000, `DATA_LAST});
   assign lower_word   = data_word[lower_index[4:0]];
   assign upper_word   = data_word[upper_index[4:0]];

   range_eval u_range_eval
   (
      .value_in (value_held),
      .lower_in (lower_word),
      .upper_in (upper_word),
      .hit_out  (range_hit)
   );

   assign hit_mask = 16'h0001 << range_index;

   always @*
   begin
      next_state        = state;
      next_base_index   = base_index;
      next_range_index  = range_index;
      next_value_held   = value_held;
      next_result_acc   = result_acc;
      next_result       = result_out;
      next_result_valid = 1'b0;
      // Flags hold unless a compare actually executes this scan.
      next_greater      = greater_flag_out;
      next_equal        = equal_flag_out;
      next_less         = less_flag_out;
      next_error        = error_flag_out;
      case (state)
         `ST_IDLE:
         begin
            if (word_go)
            begin
               // One-cycle compare; exactly one flag comes up.
               next_greater = (first_word_in > second_word_in);
               next_equal   = (first_word_in == second_word_in);
               next_less    = (first_word_in < second_word_in);
               next_error   = 1'b0;
            end
            else if (block_go)
            begin
               if (!pointer_ok)
               begin
                  next_error = 1'b1;
               end
               else
               begin
                  next_state       = `ST_RUN;
                  next_base_index  = start_index;
                  next_range_index = 4'h0;
                  next_value_held  = compare_value_in;
                  // Every bit starts clear so bits past N read as zero.
                  next_result_acc  = 16'h0000;
               end
            end
         end
         `ST_RUN:
         begin
            if (!base_in_area || !limits_in_area ||
                (range_count > `RANGE_MAX))
            begin
               // A word past the area aborts the run; result is kept.
               next_state = `ST_IDLE;
               next_error = 1'b1;
            end
            else
            begin
               if (range_hit)
               begin
                  next_result_acc = result_acc | hit_mask;
               end
               if (range_index >= range_count)
               begin
                  // Last range done: the whole result word is rewritten.
                  next_state        = `ST_IDLE;
                  next_result       = next_result_acc;
                  next_result_valid = 1'b1;
                  next_error        = 1'b0;
               end
               else
               begin
                  next_range_index = range_index + 4'h1;
               end
            end
         end
         default:
         begin
            next_state = `ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state            <= `ST_IDLE;
         base_index       <= 14'h0000;
         range_index      <= 4'h0;
         value_held       <= `WORD_RESET;
         result_acc       <= `WORD_RESET;
         result_out       <= `WORD_RESET;
         result_valid_out <= 1'b0;
         busy_out         <= 1'b0;
         greater_flag_out <= 1'b0;
         equal_flag_out   <= 1'b0;
         less_flag_out    <= 1'b0;
         error_flag_out   <= 1'b0;
         flag_word_out    <= `WORD_RESET;
      end
      else
      begin
         state            <= next_state;
         base_index       <= next_base_index;
         range_index      <= next_range_index;
         value_held       <= next_value_held;
         result_acc       <= next_result_acc;
         result_out       <= next_result;
         result_valid_out <= next_result_valid;
         busy_out         <= (next_state == `ST_RUN);
         greater_flag_out <= next_greater;
         equal_flag_out   <= next_equal;
         less_flag_out    <= next_less;
         error_flag_out   <= next_error;
         flag_word_out                <= `WORD_RESET;
         flag_word_out[`FLAG_GREATER] <= next_greater;
         flag_word_out[`FLAG_EQUAL]   <= next_equal;
         flag_word_out[`FLAG_LESS]    <= next_less;
         flag_word_out[`FLAG_ERROR]   <= next_error;
      end
   end

endmodule

// file: block_range_compare_asserts.sv
`timescale 1ns/100ps
module block_range_compare_asserts
(
   input wire        clk_in,
   input wire        rstn_in,
   input wire        exec_cond_in,
   input wire        word_compare_op_in,
   input wire [15:0] first_word_in,
   input wire [15:0] second_word_in,
   input wire        block_range_compare_op_in,
   input wire        greater_flag_out,
   input wire        equal_flag_out,
   input wire        less_flag_out,
   input wire        error_flag_out,
   input wire [15:0] flag_word_out,
   input wire        result_valid_out,
   input wire        busy_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   wire       go_w = word_compare_op_in && exec_cond_in && !busy_out;
   wire       go_b = block_range_compare_op_in && exec_cond_in && !busy_out
                     && !word_compare_op_in;
   wire [2:0] gel  = {greater_flag_out, equal_flag_out, less_flag_out};
   a_word_greater: assert property (
      go_w && first_word_in > second_word_in |=> gel == 3'b100)
      else $error("greater flag wrong");
   a_word_less: assert property (
      go_w && first_word_in < second_word_in |=> gel == 3'b001)
      else $error("less flag wrong");
   a_word_equal: assert property (
      go_w && first_word_in == second_word_in |=> gel == 3'b010)
      else $error("equal flag wrong");
   a_word_one_hot: assert property (go_w |=> $onehot(gel))
      else $error("flags not one hot");
   a_flags_hold: assert property (!go_w |=> $stable(gel))
      else $error("flags moved without compare");
   a_flag_word_map: assert property (
      flag_word_out == {gel, 1'b0, error_flag_out, 11'h000})
      else $error("flag word mismatch");
   a_block_start: assert property (go_b |=> busy_out || error_flag_out)
      else $error("block compare not started");
   a_run_ends: assert property ($rose(busy_out) |-> ##[1:10] !busy_out)
      else $error("run too long");
   a_run_outcome: assert property (
      $fell(busy_out) |-> result_valid_out ^ error_flag_out)
      else $error("run ended without one outcome");
   a_valid_pulse: assert property (
      result_valid_out |-> $past(busy_out) ##1 !result_valid_out)
      else $error("valid pulse wrong");
   a_cond_off: assert property (
      block_range_compare_op_in && !exec_cond_in && !busy_out
      && !word_compare_op_in |=> !busy_out && !result_valid_out)
      else $error("block ran with condition off");
   c_word: cover property (go_w);
   c_result: cover property (result_valid_out);
   c_error: cover property ($rose(error_flag_out));
endmodule
bind block_range_compare block_range_compare_asserts u_asserts (.*);

// file: issue_model.sv
`timescale 1ns/100ps
// Sequencer side: issues compares and keeps a shadow of the data words.
module issue_model
(
   input  wire        clk_in,
   input  wire        busy_out,
   output reg         exec_cond_in,
   output reg         word_compare_op_in,
   output reg  [15:0] first_word_in,
   output reg  [15:0] second_word_in,
   output reg         block_range_compare_op_in,
   output reg  [15:0] compare_value_in,
   output reg  [4:0]  block_base_word_in,
   output reg         base_indirect_in,
   output reg         wr_en_in,
   output reg  [4:0]  wr_addr_in,
   output reg  [15:0] wr_data_in
);
   reg [15:0]   mem [0:31];
   reg [4:0]    mid_a = 5'h00;
   reg [15:0]   mid_d = 16'h0000;
   logic [15:0] exp_q [$];
   initial
   begin
      {exec_cond_in, word_compare_op_in, first_word_in, second_word_in} = '0;
      {block_range_compare_op_in, compare_value_in, block_base_word_in} = '0;
      {base_indirect_in, wr_en_in, wr_addr_in, wr_data_in} = '0;
      for (int i = 0; i < 32; i++)
         mem[i] = 16'h0000;
   end
   function automatic logic [15:0] calc(input [15:0] v, input [4:0] b);
      logic [15:0] r;
      logic [15:0] lo;
      logic [15:0] hi;
      begin
         r = 16'h0000;
         for (int k = 0; k <= mem[b][3:0]; k++)
         begin
            lo = mem[b + 2 * k + 1];
            hi = mem[b + 2 * k + 2];
            r[k] = lo <= hi ? v >= lo && v <= hi : v >= lo || v <= hi;
         end
         calc = r;
      end
   endfunction
   task wr(input [4:0] a, input [15:0] d);
      begin
         @(posedge clk_in) #1;
         wr_en_in = 1'b1;
         wr_addr_in = a;
         wr_data_in = d;
         mem[a] = d;
         @(posedge clk_in) #1;
         wr_en_in = 1'b0;
      end
   endtask
   task wcmp(input c, input [15:0] x, input [15:0] y);
      begin
         @(posedge clk_in) #1;
         exec_cond_in = c;
         word_compare_op_in = 1'b1;
         first_word_in = x;
         second_word_in = y;
         @(posedge clk_in) #1;
         word_compare_op_in = 1'b0;
      end
   endtask
   // A write set up in mid_a lands one cycle after issue, during the run.
   task bcmp(input c, input [15:0] v, input [4:0] b, input ind, input ok);
      logic [4:0] eb;
      begin
         @(posedge clk_in) #1;
         exec_cond_in = c;
         block_range_compare_op_in = 1'b1;
         compare_value_in = v;
         block_base_word_in = b;
         base_indirect_in = ind;
         eb = ind ? 5'(mem[b][7:4] * 10 + mem[b][3:0]) : b;
         if (mid_a != 5'h00)
            mem[mid_a] = mid_d;
         if (ok)
            exp_q.push_back(calc(v, eb));
         @(posedge clk_in) #1;
         block_range_compare_op_in = 1'b0;
         wr_en_in = mid_a != 5'h00;
         wr_addr_in = mid_a;
         wr_data_in = mid_d;
         mid_a = 5'h00;
         for (int i = 0; i < 14 && busy_out; i++)
            @(posedge clk_in) #1;
         wr_en_in = 1'b0;
      end
   endtask
endmodule

// file: block_range_compare_tb_top.sv
`timescale 1ns/100ps
module block_range_compare_tb_top;
   reg         clk_in = 1'b0;
   reg         rstn_in = 1'b0;
   wire        exec_cond_in, word_compare_op_in, block_range_compare_op_in;
   wire        base_indirect_in, wr_en_in, busy_out, result_valid_out;
   wire        greater_flag_out, equal_flag_out, less_flag_out, error_flag_out;
   wire [15:0] first_word_in, second_word_in, compare_value_in, wr_data_in;
   wire [15:0] rd_data_out, flag_word_out, result_out;
   wire [4:0]  block_base_word_in, wr_addr_in;
   reg  [4:0]  rd_addr_in = 5'h00;
   integer     seed = 32'hfa5d;
   integer     mismatches = 0;
   integer     checks = 0;
   logic [3:0] n;
   logic [4:0] b;
   logic [15:0] x;
   logic [15:0] cvs [0:4] = '{16'h0050, 16'h0100, 16'h0200, 16'h0300, 16'h0301};
   logic [15:0] tab [0:12] = '{16'h0005, 16'h0000, 16'h0100, 16'h0101,
      16'h0200, 16'h0201, 16'h0300, 16'h0501, 16'h0600, 16'h1401, 16'h1500,
      16'h1501, 16'h1600};
   block_range_compare u_dut (.*);
   issue_model u_seq (.*);
   always #10 clk_in = ~clk_in;
   task check(input [15:0] seen, input [15:0] want);
      begin
         checks = checks + 1;
         if (seen !== want)
         begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
         end
      end
   endtask
   task close_out;
      begin
         $display("mismatches %0d checks %0d", mismatches, checks);
         if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   function automatic logic [15:0] bcd();
      for (int d = 0; d < 4; d++)
         bcd = {bcd[11:0], 4'($unsigned($random(seed)) % 10)};
   endfunction
   task wtest(input c, input [15:0] p, input [15:0] q);
      logic [15:0] want;
      begin
         want = c ? {p > q, p == q, p < q, 13'h0000} : flag_word_out;
         u_seq.wcmp(c, p, q);
         check(flag_word_out, want);
      end
   endtask
   always @(posedge clk_in)
      if (result_valid_out === 1'b1)
         check(result_out, u_seq.exp_q.size() ? u_seq.exp_q.pop_front()
               : ~result_out);
   initial
   begin
      #400000;
      mismatches = mismatches + 1;
      close_out;
   end
   initial
   begin
      repeat (10) @(posedge clk_in);
      #1 rstn_in = 1'b1;
      for (int i = 0; i < 40; i++)
      begin
         x = bcd();
         wtest(i % 5 != 4, x, i % 3 == 0 ? x : bcd());
      end
      for (int i = 0; i < 13; i++)
         u_seq.wr(5'(i), tab[i]);
      for (int i = 0; i < 13; i++)
      begin
         @(posedge clk_in) #1;
         rd_addr_in = 5'(i);
         @(posedge clk_in) #1;
         check(rd_data_out, tab[i]);
      end
      u_seq.bcmp(1'b1, 16'h0210, 5'h00, 1'b0, 1'b1);
      u_seq.bcmp(1'b1, 16'h0210, 5'h00, 1'b0, 1'b1);
      u_seq.bcmp(1'b0, 16'h0210, 5'h00, 1'b0, 1'b0);
      u_seq.mid_a = 5'h06;
      u_seq.mid_d = 16'h0205;
      u_seq.bcmp(1'b1, 16'h0210, 5'h00, 1'b0, 1'b1);
      u_seq.wr(5'h0d, 16'h0000);
      u_seq.wr(5'h0e, 16'h0300);
      for (int e = 0; e < 2; e++)
      begin
         u_seq.wr(5'h0f, e ? 16'h0300 : 16'h0100);
         for (int i = 0; i < 5; i++)
            u_seq.bcmp(1'b1, cvs[i], 5'h0d, 1'b0, 1'b1);
      end
      for (int r = 0; r < 20; r++)
      begin
         n = 4'($unsigned($random(seed)) % 10);
         b = 5'($unsigned($random(seed)) % (n == 9 ? 12 : 14));
         for (int i = 1; i <= 2 * n + 2; i++)
            u_seq.wr(5'(b + i), bcd());
         u_seq.wr(b, {12'h000, n});
         u_seq.bcmp(1'b1, bcd(), b, 1'b0, 1'b1);
      end
      u_seq.wr(5'h0d, 16'h0009);
      u_seq.bcmp(1'b1, 16'h0000, 5'h0d, 1'b0, 1'b0);
      check(flag_word_out & 16'h0800, 16'h0800);
      wtest(1'b1, 16'h9999, 16'h0000);
      u_seq.wr(5'h14, 16'h00a0);
      u_seq.bcmp(1'b1, 16'h0000, 5'h14, 1'b1, 1'b0);
      check(flag_word_out & 16'h0800, 16'h0800);
      u_seq.wr(5'h14, 16'h0000);
      u_seq.bcmp(1'b1, 16'h0210, 5'h14, 1'b1, 1'b1);
      wtest(1'b1, 16'h0000, 16'h0000);
      repeat (3) @(posedge clk_in);
      check(16'(u_seq.exp_q.size()), 16'h0000);
      close_out;
   end
endmodule
